// >>> verilog/scan_port_defines.svh
// Purpose: Constants for the serial test port and its scan registers
// Assumes: Single system clock domain; test clock sampled as data
`ifndef SCAN_PORT_DEFINES_SVH
`define SCAN_PORT_DEFINES_SVH

`define INSTR_REG_ADDR 32'h0400_0200
`define INSTR_REG_RESET 16'hffff
`define INSTR_CODE_MSB 15
`define INSTR_CODE_LSB 12
`define INSTR_LOW_ONES 12'hfff
`define CHAIN_LEN 339
`define CHAIN_TOP 338
`define DATA_IN_LSB 307
`define DATA_OUT_LSB 267
`define DATA_CTL_LSB 235
`define DATA_WIDTH 32
`define CODE_EXTEST 4'h0
`define CODE_SAMPLE 4'h4
`define CODE_SLEEP_REC 4'h1
`define CODE_RST_NEGATE 4'h6
`define CODE_RST_ASSERT 4'h7
`define CODE_IRQ_HI 3'h5
`define CODE_BYPASS 4'hf

`endif

// >>> verilog/scan_port_pkg.sv
// Purpose: Types for the serial test port
// Assumes: Nothing beyond the constants header
// Notes: State names follow the standard test access port
package scan_port_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_type;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } link_in_type;

    typedef struct packed {
        logic extest;
        logic sample;
        logic sleep_recover;
        logic reset_negate;
        logic reset_assert;
        logic irq_cmd;
        logic bypass;
    } decode_type;

endpackage

// >>> verilog/sync_two_ff.sv
// Purpose: Two flip-flop synchroniser for a bundle of levels
// Assumes: Inputs asynchronous to clk
// Notes: First stage read only by second stage
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/scan_test_port.sv
// Purpose: Serial test port with bypass, instruction and boundary registers
// Assumes: Test clock, mode, data and reset are asynchronous pins
// Notes: Core side of the boundary cells is given as plain vectors
`include "scan_port_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module scan_test_port #(
    parameter int CHAIN_LEN = `CHAIN_LEN
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    input wire logic cpu_rd,
    input wire logic [31:0] cpu_addr,
    output logic [15:0] cpu_rdata,
    input wire logic [CHAIN_LEN-1:0] pad_in,
    output logic [CHAIN_LEN-1:0] chain_upd,
    output logic extest_mode,
    output logic [`DATA_WIDTH-1:0] data_pin_out,
    output logic [`DATA_WIDTH-1:0] data_pin_oe,
    output logic test_port_reset_req,
    output logic test_port_irq_cmd,
    output logic sleep_recover_req
);
    logic rst_s1_r;
    logic rst_n_r;
    scan_port_pkg::link_in_type link_s;
    logic trst_n_s;
    logic tck_d_r;
    logic rise;
    logic fall;
    scan_port_pkg::tap_state_type tap_r;
    scan_port_pkg::tap_state_type tap_nxt;
    logic [15:0] ir_shift_r;
    logic [15:0] test_instruction_reg;
    logic test_bypass_cell;
    logic [CHAIN_LEN-1:0] pin_scan_chain;
    logic tdi_r;
    scan_port_pkg::decode_type dec;
    logic [3:0] code;
    logic ser_out;
    logic [CHAIN_LEN-1:0] pad_s;
    logic shift_dr_r;
    logic shift_ir_r;
    logic fall_d_r;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    sync_two_ff #(.WIDTH(3), .INIT(3'b000)) u_link_sync (
        .clk(sys_clk),
        .rst_n(rst_n_r),
        .d({tck, tms, tdi}),
        .q(link_s)
    );

    // Test reset synchronised for the state and instruction registers only
    sync_two_ff #(.WIDTH(1), .INIT(1'b0)) u_trst_sync (
        .clk(sys_clk),
        .rst_n(rst_n_r),
        .d(trst_n),
        .q(trst_n_s)
    );

    // Pad levels come from pins; synchronise before capture
    sync_two_ff #(.WIDTH(CHAIN_LEN), .INIT('0)) u_pad_sync (
        .clk(sys_clk),
        .rst_n(rst_n_r),
        .d(pad_in),
        .q(pad_s)
    );

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= link_s.tck;
        end
    end

    assign rise = link_s.tck & ~tck_d_r;
    assign fall = ~link_s.tck & tck_d_r;

    always_comb begin
        tap_nxt = tap_r;
        case (tap_r)
            scan_port_pkg::TAP_RESET: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_RESET : scan_port_pkg::TAP_IDLE;
            end
            scan_port_pkg::TAP_IDLE: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_SEL_DR : scan_port_pkg::TAP_IDLE;
            end
            scan_port_pkg::TAP_SEL_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_SEL_IR : scan_port_pkg::TAP_CAP_DR;
            end
            scan_port_pkg::TAP_CAP_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_EXIT1_DR : scan_port_pkg::TAP_SHIFT_DR;
            end
            scan_port_pkg::TAP_SHIFT_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_EXIT1_DR : scan_port_pkg::TAP_SHIFT_DR;
            end
            scan_port_pkg::TAP_EXIT1_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_UPD_DR : scan_port_pkg::TAP_PAUSE_DR;
            end
            scan_port_pkg::TAP_PAUSE_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_EXIT2_DR : scan_port_pkg::TAP_PAUSE_DR;
            end
            scan_port_pkg::TAP_EXIT2_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_UPD_DR : scan_port_pkg::TAP_SHIFT_DR;
            end
            scan_port_pkg::TAP_UPD_DR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_SEL_DR : scan_port_pkg::TAP_IDLE;
            end
            scan_port_pkg::TAP_SEL_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_RESET : scan_port_pkg::TAP_CAP_IR;
            end
            scan_port_pkg::TAP_CAP_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_EXIT1_IR : scan_port_pkg::TAP_SHIFT_IR;
            end
            scan_port_pkg::TAP_SHIFT_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_EXIT1_IR : scan_port_pkg::TAP_SHIFT_IR;
            end
            scan_port_pkg::TAP_EXIT1_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_UPD_IR : scan_port_pkg::TAP_PAUSE_IR;
            end
            scan_port_pkg::TAP_PAUSE_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_EXIT2_IR : scan_port_pkg::TAP_PAUSE_IR;
            end
            scan_port_pkg::TAP_EXIT2_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_UPD_IR : scan_port_pkg::TAP_SHIFT_IR;
            end
            scan_port_pkg::TAP_UPD_IR: begin
                tap_nxt = link_s.tms ? scan_port_pkg::TAP_SEL_DR : scan_port_pkg::TAP_IDLE;
            end
            default: begin
                tap_nxt = scan_port_pkg::TAP_RESET;
            end
        endcase
    end

    // Raw pin reset acts at once, no clock edge needed
    always_ff @(posedge sys_clk or negedge rst_n_r or negedge trst_n) begin
        if (!rst_n_r || !trst_n) begin
            tap_r <= scan_port_pkg::TAP_RESET;
        end else if (!trst_n_s) begin
            tap_r <= scan_port_pkg::TAP_RESET;
        end else if (rise) begin
            tap_r <= tap_nxt;
        end
    end

    // Bit sampled in a shift state is shifted at the next fall
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            shift_dr_r <= 1'b0;
            shift_ir_r <= 1'b0;
            fall_d_r <= 1'b0;
        end else begin
            fall_d_r <= fall;
            if (tap_r == scan_port_pkg::TAP_RESET) begin
                shift_dr_r <= 1'b0;
                shift_ir_r <= 1'b0;
            end else if (rise) begin
                shift_dr_r <= (tap_r == scan_port_pkg::TAP_SHIFT_DR);
                shift_ir_r <= (tap_r == scan_port_pkg::TAP_SHIFT_IR);
            end
        end
    end

    // Serial input sampled on rising edge
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tdi_r <= 1'b0;
        end else if (rise) begin
            tdi_r <= link_s.tdi;
        end
    end

    // Instruction register, written only from the test port in any CPU mode
    always_ff @(posedge sys_clk or negedge rst_n_r or negedge trst_n) begin
        if (!rst_n_r || !trst_n) begin
            test_instruction_reg <= `INSTR_REG_RESET;
            ir_shift_r <= `INSTR_REG_RESET;
        end else if (!trst_n_s || tap_r == scan_port_pkg::TAP_RESET) begin
            test_instruction_reg <= `INSTR_REG_RESET;
            ir_shift_r <= `INSTR_REG_RESET;
        end else if (rise && tap_r == scan_port_pkg::TAP_CAP_IR) begin
            ir_shift_r <= test_instruction_reg;
        end else if (fall && shift_ir_r) begin
            ir_shift_r <= {tdi_r, ir_shift_r[15:1]};
        end else if (rise && tap_r == scan_port_pkg::TAP_UPD_IR) begin
            test_instruction_reg <= {ir_shift_r[15:12], `INSTR_LOW_ONES};
        end
    end

    assign code = test_instruction_reg[`INSTR_CODE_MSB:`INSTR_CODE_LSB];

    // Reserved codes left undecoded; tester keeps off them
    always_comb begin
        dec = '0;
        dec.extest = (code == `CODE_EXTEST);
        dec.sample = (code == `CODE_SAMPLE);
        dec.sleep_recover = (code == `CODE_SLEEP_REC);
        dec.reset_negate = (code == `CODE_RST_NEGATE);
        dec.reset_assert = (code == `CODE_RST_ASSERT);
        dec.irq_cmd = (code[3:1] == `CODE_IRQ_HI);
        dec.bypass = (code == `CODE_BYPASS);
    end

    // Single bypass cell, no CPU address
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            test_bypass_cell <= 1'b0;
        end else if (rise && tap_r == scan_port_pkg::TAP_CAP_DR) begin
            test_bypass_cell <= 1'b0;
        end else if (fall && shift_dr_r) begin
            test_bypass_cell <= tdi_r;
        end
    end

    // Chain shifts toward cell 0; cell 338 takes serial input
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pin_scan_chain <= '0;
        end else if (dec.extest || dec.sample) begin
            if (rise && tap_r == scan_port_pkg::TAP_CAP_DR) begin
                pin_scan_chain <= pad_s;
            end else if (fall && shift_dr_r) begin
                pin_scan_chain <= {tdi_r, pin_scan_chain[CHAIN_LEN-1:1]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            chain_upd <= '0;
        end else if (rise && tap_r == scan_port_pkg::TAP_UPD_DR && (dec.extest || dec.sample)) begin
            chain_upd <= pin_scan_chain;
        end
    end

    always_comb begin
        ser_out = test_bypass_cell;
        if (tap_r == scan_port_pkg::TAP_SHIFT_IR) begin
            ser_out = ir_shift_r[0];
        end else if (dec.extest || dec.sample) begin
            ser_out = pin_scan_chain[0];
        end
    end

    // Serial output follows the falling edge, after that edge's shift
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tap_r == scan_port_pkg::TAP_RESET) begin
            tdo_oe <= 1'b0;
        end else if (fall_d_r) begin
            tdo <= ser_out;
            tdo_oe <= (tap_r == scan_port_pkg::TAP_SHIFT_DR) ||
                      (tap_r == scan_port_pkg::TAP_SHIFT_IR);
        end
    end

    // Data bus pad drive under external test
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            extest_mode <= 1'b0;
            data_pin_out <= '0;
            data_pin_oe <= '0;
        end else begin
            extest_mode <= dec.extest;
            data_pin_out <= chain_upd[`DATA_OUT_LSB +: `DATA_WIDTH];
            data_pin_oe <= dec.extest ? ~chain_upd[`DATA_CTL_LSB +: `DATA_WIDTH] : '0;
        end
    end

    // Command outputs; reset request held from assert to negate
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            test_port_reset_req <= 1'b0;
            test_port_irq_cmd <= 1'b0;
            sleep_recover_req <= 1'b0;
        end else begin
            if (dec.reset_assert) begin
                test_port_reset_req <= 1'b1;
            end else if (dec.reset_negate) begin
                test_port_reset_req <= 1'b0;
            end
            test_port_irq_cmd <= dec.irq_cmd;
            sleep_recover_req <= dec.sleep_recover;
        end
    end

    // CPU read port; writes are not taken
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cpu_rdata <= '0;
        end else if (cpu_rd && cpu_addr == `INSTR_REG_ADDR) begin
            cpu_rdata <= test_instruction_reg;
        end else begin
            cpu_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// >>> sim/scan_test_port_monitor.sv
// Purpose: Port checker for the serial test port
// Assumes: Bound to every scan_test_port instance
// Notes: Output stages may lag the update latch by one cycle
`include "scan_port_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module scan_test_port_monitor #(
    parameter int CHAIN_LEN = 339
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic cpu_rd,
    input wire logic [31:0] cpu_addr,
    input wire logic [15:0] cpu_rdata,
    input wire logic [CHAIN_LEN-1:0] pad_in,
    input wire logic [CHAIN_LEN-1:0] chain_upd,
    input wire logic extest_mode,
    input wire logic [31:0] data_pin_out,
    input wire logic [31:0] data_pin_oe,
    input wire logic test_port_reset_req,
    input wire logic test_port_irq_cmd,
    input wire logic sleep_recover_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic hit;
    assign hit = cpu_rd && cpu_addr == `INSTR_REG_ADDR;
    AST_RD_LOW_ONES: assert property (hit |=> cpu_rdata[11:0] == 12'hfff)
        else $error("low instruction bits not ones");
    AST_RD_OTHER: assert property (cpu_rd && !hit |=> cpu_rdata == 16'h0000)
        else $error("read data at other address");
    AST_TRST_IR: assert property (!trst_n && hit |=> cpu_rdata == 16'hffff)
        else $error("instruction not all ones in test reset");
    AST_TRST_OE: assert property (!trst_n |-> ##[0:3] !tdo_oe)
        else $error("serial out still driven in test reset");
    AST_TRST_DEC: assert property ($fell(trst_n) |->
        ##[1:4] !(extest_mode | test_port_irq_cmd | sleep_recover_req))
        else $error("decode outputs not cleared by test reset");
    AST_DEC_EXCL: assert property ($onehot0({extest_mode, test_port_irq_cmd,
        sleep_recover_req}))
        else $error("two instruction outputs active");
    AST_PIN_OUT: assert property ($stable(chain_upd) |->
        data_pin_out == chain_upd[298:267])
        else $error("pin output not from output cells");
    AST_PIN_OE: assert property (extest_mode && $past(extest_mode) && $stable(chain_upd)
        |-> data_pin_oe == ~chain_upd[266:235])
        else $error("pin enable not from low control cells");
    AST_PIN_OE_OFF: assert property (!extest_mode && !$past(extest_mode) |->
        data_pin_oe == 32'h0000_0000)
        else $error("pin driven outside external test");
    AST_TDO_FALL: assert property (tdo_oe && $past(tdo_oe) && $changed(tdo) |->
        !$past(tck, 2))
        else $error("serial out changed away from falling edge");
    cover property (extest_mode && data_pin_oe != 32'h0000_0000);
    cover property (test_port_irq_cmd);
    cover property ($fell(trst_n) && tdo_oe);
endmodule
bind scan_test_port scan_test_port_monitor #(.CHAIN_LEN(CHAIN_LEN)) mon_i (.sys_clk,
    .resetn, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .cpu_rd, .cpu_addr, .cpu_rdata,
    .pad_in, .chain_upd, .extest_mode, .data_pin_out, .data_pin_oe,
    .test_port_reset_req, .test_port_irq_cmd, .sleep_recover_req);
`default_nettype wire

// >>> sim/scan_tester_model.sv
// Purpose: Boundary scan tester driving the test link
// Assumes: Test clock 200 ns, stopped between scans
// Notes: Serial out read late in the high phase
`timescale 1ns/100ps
`default_nettype none
module scan_tester_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic so;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
        so = 1'b0;
    end
    // Out value stands until the next fall, so a late read equals the rising one
    task automatic tick(input logic m, input logic d);
        tms = m;
        tdi = d;
        #100 tck = 1'b1;
        #90 so = tdo_oe ? tdo : ~so;
        #10 tck = 1'b0;
    endtask
    task automatic tap_reset();
        repeat (5) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask
    // From idle, n bits LSB first, back to idle
    task automatic scan(input logic ir, input int n, input logic [338:0] din,
        output logic [338:0] dout);
        dout = '0;
        tick(1'b1, 1'b0);
        if (ir) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        for (int k = 0; k < n; k++) begin
            tick(k == n - 1, din[k]);
            dout[k] = so;
        end
        tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask
    task automatic pulse_trst();
        trst_n = 1'b0;
        #300 trst_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_scan_test_port.sv
// Purpose: Scenario bench for the serial test port
// Assumes: Tester model owns the test link pins
// Notes: Long chain scans dominate run time
`include "scan_port_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_scan_test_port;
    logic sys_clk, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe, cpu_rd;
    logic [31:0] cpu_addr, data_pin_out, data_pin_oe;
    logic [15:0] cpu_rdata;
    logic [338:0] pad_in, chain_upd, dout;
    logic extest_mode, test_port_reset_req, test_port_irq_cmd, sleep_recover_req;
    int error_cnt = 0;
    int total_checks = 0;
    scan_test_port scan_test_port_i (.sys_clk, .resetn, .tck, .tms, .tdi, .trst_n,
        .tdo, .tdo_oe, .cpu_rd, .cpu_addr, .cpu_rdata, .pad_in, .chain_upd,
        .extest_mode, .data_pin_out, .data_pin_oe, .test_port_reset_req,
        .test_port_irq_cmd, .sleep_recover_req);
    scan_tester_model scan_tester_model_i (.tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [338:0] exp,
        input logic [338:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cpu_read(input logic [31:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        #1 cpu_rd = 1'b1;
        cpu_addr = a;
        @(posedge sys_clk);
        #1 cpu_rd = 1'b0;
        check("cpu_rdata", exp, cpu_rdata);
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic reset_values();
        cpu_read(`INSTR_REG_ADDR, 16'hffff);
        cpu_read(32'h0400_0204, 16'h0000);
        check("tdo_oe", 1'b0, tdo_oe);
    endtask
    task automatic code_table();
        logic [3:0] codes [8] = '{4'h7, 4'h0, 4'h4, 4'h1, 4'ha, 4'hb, 4'h6, 4'hf};
        logic [3:0] prev;
        logic rq;
        prev = 4'hf;
        rq = 1'b0;
        foreach (codes[i]) begin
            scan_tester_model_i.scan(1'b1, 16, {323'h0, codes[i], 12'hfff}, dout);
            rq = (codes[i] == 4'h7) ? 1'b1 : ((codes[i] == 4'h6) ? 1'b0 : rq);
            cpu_read(`INSTR_REG_ADDR, {codes[i], 12'hfff});
            check("ir_capture", {prev, 12'hfff}, dout[15:0]);
            check("extest_mode", codes[i] == 4'h0, extest_mode);
            check("irq_cmd", codes[i][3:1] == 3'b101, test_port_irq_cmd);
            check("sleep_req", codes[i] == 4'h1, sleep_recover_req);
            check("reset_req", rq, test_port_reset_req);
            prev = codes[i];
        end
    endtask
    task automatic bypass_path();
        repeat (2) begin
            scan_tester_model_i.scan(1'b0, 8, 339'h9d, dout);
            check("bypass_out", 8'h3a, dout[7:0]);
        end
    endtask
    task automatic boundary_scan();
        logic [338:0] v;
        v = '0;
        v[298:267] = 32'ha5c3_0f96;
        scan_tester_model_i.scan(1'b1, 16, {323'h0, 4'h4, 12'hfff}, dout);
        scan_tester_model_i.scan(1'b0, 339, v, dout);
        check("sample_capture", pad_in, dout);
        check("chain_upd", v, chain_upd);
        check("pin_oe", 32'h0000_0000, data_pin_oe);
        scan_tester_model_i.scan(1'b1, 16, {323'h0, 4'h0, 12'hfff}, dout);
        check("pin_out", 32'ha5c3_0f96, data_pin_out);
        check("pin_oe", 32'hffff_ffff, data_pin_oe);
        v[266:251] = 16'hffff;
        scan_tester_model_i.scan(1'b0, 339, v, dout);
        check("extest_capture", pad_in, dout);
        check("pin_oe", 32'h0000_ffff, data_pin_oe);
    endtask
    task automatic trst_mid_shift();
        for (int k = 0; k < 5; k++) scan_tester_model_i.tick(k < 2, 1'b0);
        check("tdo_oe", 1'b1, tdo_oe);
        fork
            scan_tester_model_i.pulse_trst();
            cpu_read(`INSTR_REG_ADDR, 16'hffff);
        join
        check("tdo_oe", 1'b0, tdo_oe);
        check("extest_mode", 1'b0, extest_mode);
        cpu_read(`INSTR_REG_ADDR, 16'hffff);
        scan_tester_model_i.tap_reset();
    endtask
    initial begin
        resetn = 1'b0;
        cpu_rd = 1'b0;
        cpu_addr = 32'h0000_0000;
        pad_in = 339'({11{32'h3c96_a5f1}});
        repeat (6) @(posedge sys_clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        scan_tester_model_i.tap_reset();
        reset_values();
        code_table();
        bypass_path();
        boundary_scan();
        trst_mid_shift();
        give_verdict();
    end
    initial begin
        #2000000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
